/* File: src/dut_timing_irq.sv */
// Baud generator, clock selectors, counter/timer and interrupt control
`timescale 1ns/1ps
`default_nettype none
module dut_timing_irq
	import dut_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [2:0] cmd,
	input wire logic [15:0] wr_data,
	input wire logic wr_mask,
	input wire logic [4:0] wr_opcfg,
	input wire logic rd_rx_holding_a,
	input wire logic rd_rx_holding_b,
	input wire logic wr_tx_holding_a,
	input wire logic wr_tx_holding_b,
	input wire logic rd_input_change,
	input wire logic brk_reset_a,
	input wire logic brk_reset_b,
	input wire logic [7:0] event_set,
	input wire logic use_ext_ct_clk,
	input wire logic counter_ext_clock,
	input wire logic rx_ext_clock_a,
	input wire logic rx_ext_clock_b,
	input wire logic tx_ext_clock_a,
	input wire logic tx_ext_clock_b,
	input wire logic rx_char_a,
	input wire logic [4:0] sel_rx_a,
	input wire logic [4:0] sel_tx_a,
	input wire logic [4:0] sel_rx_b,
	input wire logic [4:0] sel_tx_b,
	output logic access,
	output logic access_start,
	output logic access_end,
	output logic combined_irq_out_n,
	output logic [7:0] irq_status_reg,
	output logic [7:0] irq_mask_reg,
	output logic [4:0] out_pins_three_to_seven,
	output logic [15:0] count_value,
	output logic ct_out,
	output logic [3:0] clk16_en
);
	////////////////////////////////////////////////////////////////////////
	// Bus access tracking
	logic cs_lvl, rd_lvl, wr_lvl; // Synchronised active-high versions
	logic access_r; // Previous access level
	dut_edge u_cs (.clk(clk), .rst(rst), .din(~chip_select_n), .level(cs_lvl), .rise());
	dut_edge u_rd (.clk(clk), .rst(rst), .din(~read_strobe_n), .level(rd_lvl), .rise());
	dut_edge u_wr (.clk(clk), .rst(rst), .din(~write_strobe_n), .level(wr_lvl), .rise());
	// Last to assert starts, first to drop ends
	assign access = cs_lvl & (rd_lvl | wr_lvl);
	always_ff @(posedge clk) begin
		if (rst) access_r <= 1'b0;
		else access_r <= access;
	end
	assign access_start = access & ~access_r;
	assign access_end = ~access & access_r;

	////////////////////////////////////////////////////////////////////////
	// Baud generator: one half-period counter per tap
	logic [DUT_BAUD_N-1:0] tap_r; // 16X square waves
	logic [DUT_BAUD_N-1:0] tap_tick; // Rising edge pulses
	genvar g;
	generate
		for (g = 0; g < DUT_BAUD_N; g++) begin : g_tap
			logic [11:0] cnt_r;
			// Divide oscillator by fixed ratio
			always_ff @(posedge clk) begin
				if (rst) begin
					cnt_r <= 12'h000;
					tap_r[g] <= 1'b0;
				end else if (cnt_r >= DUT_BAUD_HALF[g] - 12'h001) begin
					cnt_r <= 12'h000;
					tap_r[g] <= ~tap_r[g];
				end else begin
					cnt_r <= cnt_r + 12'h001;
				end
			end
			assign tap_tick[g] = (cnt_r >= DUT_BAUD_HALF[g] - 12'h001) & ~tap_r[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// External clock inputs, synchronised
	logic ctx_rise; // Counter external clock edge
	logic [3:0] ext_rise; // rxa, txa, rxb, txb
	dut_edge u_ctx (.clk(clk), .rst(rst), .din(counter_ext_clock), .level(), .rise(ctx_rise));
	dut_edge u_rxa (.clk(clk), .rst(rst), .din(rx_ext_clock_a), .level(), .rise(ext_rise[0]));
	dut_edge u_txa (.clk(clk), .rst(rst), .din(tx_ext_clock_a), .level(), .rise(ext_rise[1]));
	dut_edge u_rxb (.clk(clk), .rst(rst), .din(rx_ext_clock_b), .level(), .rise(ext_rise[2]));
	dut_edge u_txb (.clk(clk), .rst(rst), .din(tx_ext_clock_b), .level(), .rise(ext_rise[3]));

	////////////////////////////////////////////////////////////////////////
	// Counter/timer
	logic [15:0] preset_r; // count_preset_high : count_preset_low
	logic [15:0] cnt_r; // Down counter
	logic run_r; // Counting
	logic wave_r; // Square wave output
	logic ct_irq_r; // Zero-pass event
	logic [1:0] mode_r; // Current mode
	logic ct_step; // Count enable
	logic ct_zero; // Passing zero this step
	logic ct_rise; // Counter output rising, used as clock source
	logic ct_stop;
	assign ct_stop = (cmd == DUT_CMD_STOP);
	// Oscillator or external source
	assign ct_step = run_r & (use_ext_ct_clk ? ctx_rise : 1'b1);
	assign ct_zero = ct_step & (cnt_r == 16'h0000);
	assign ct_rise = ct_zero & ~wave_r & (mode_r == DUT_MODE_TIMER);
	// Preset register writes
	always_ff @(posedge clk) begin
		if (rst) preset_r <= DUT_PRESET_RST;
		else if (cmd == DUT_CMD_WR_PRESET) preset_r <= wr_data;
	end
	// Mode selection via set/reset timeout commands
	always_ff @(posedge clk) begin
		if (rst) mode_r <= DUT_MODE_TIMER;
		else if (cmd == DUT_CMD_SET_TO) mode_r <= DUT_MODE_TIMEOUT;
		else if (cmd == DUT_CMD_RST_TO) mode_r <= DUT_MODE_COUNTER;
	end
	// Run control: host commands, or receiver in timeout mode
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
		end else if (ct_stop) begin
			run_r <= 1'b0;
		end else if (mode_r == DUT_MODE_TIMEOUT) begin
			if (rx_char_a) run_r <= 1'b1;
			else if (ct_zero) run_r <= 1'b0;
		end else if (cmd == DUT_CMD_START) begin
			run_r <= 1'b1;
		end else if (ct_zero && mode_r == DUT_MODE_COUNTER) begin
			run_r <= 1'b0;
		end
	end
	// Down counter with reload
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= DUT_PRESET_RST;
		end else if (cmd == DUT_CMD_START || (mode_r == DUT_MODE_TIMEOUT && rx_char_a)) begin
			cnt_r <= preset_r;
		end else if (ct_zero && mode_r == DUT_MODE_TIMER) begin
			// Zero step counts too, so reload one less; a zero divisor wraps long
			cnt_r <= preset_r - 16'h0001;
		end else if (ct_zero) begin
			cnt_r <= preset_r;
		end else if (ct_step) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end
	// Square wave toggles each zero pass in timer mode
	always_ff @(posedge clk) begin
		if (rst) wave_r <= 1'b0;
		else if (ct_zero && mode_r == DUT_MODE_TIMER) wave_r <= ~wave_r;
	end
	// Captured value for read command
	always_ff @(posedge clk) begin
		if (rst) count_value <= 16'h0000;
		else if (cmd == DUT_CMD_RD_VALUE) count_value <= cnt_r;
	end
	// Zero pass event, stop clears it; set wins over clear
	always_ff @(posedge clk) begin
		if (rst) ct_irq_r <= 1'b0;
		else if (ct_zero) ct_irq_r <= 1'b1;
		else if (ct_stop) ct_irq_r <= 1'b0;
	end
	assign ct_out = wave_r;

	////////////////////////////////////////////////////////////////////////
	// Clock selectors, one per rx/tx
	logic [4:0] sel [4];
	assign sel[0] = sel_rx_a;
	assign sel[1] = sel_tx_a;
	assign sel[2] = sel_rx_b;
	assign sel[3] = sel_tx_b;
	generate
		for (g = 0; g < 4; g++) begin : g_sel
			// Independent choice of tap, counter or external
			always_ff @(posedge clk) begin
				if (rst) clk16_en[g] <= 1'b0;
				else if (sel[g] == DUT_SEL_CT) clk16_en[g] <= ct_rise;
				else if (sel[g] == DUT_SEL_EXT) clk16_en[g] <= ext_rise[g];
				else if (sel[g] < DUT_SEL_CT) clk16_en[g] <= tap_tick[sel[g]];
				else clk16_en[g] <= 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	logic [7:0] clr; // Service clears per bit
	logic [7:0] setv; // Set sources per bit
	logic [4:0] opcfg_r; // Discrete pin enables
	always_comb begin
		clr = 8'h00;
		clr[DUT_B_TXA] = wr_tx_holding_a;
		clr[DUT_B_TXB] = wr_tx_holding_b;
		clr[DUT_B_RXA] = rd_rx_holding_a;
		clr[DUT_B_RXB] = rd_rx_holding_b;
		clr[DUT_B_BRKA] = brk_reset_a;
		clr[DUT_B_BRKB] = brk_reset_b;
		clr[DUT_B_IPC] = rd_input_change;
		clr[DUT_B_CT] = 1'b1; // Counter bit mirrors ct_irq_r, so stop clears it
		setv = event_set;
		setv[DUT_B_CT] = 1'b0;
	end
	// Sticky status, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) irq_status_reg <= 8'h00;
		else irq_status_reg <= setv | (irq_status_reg & ~clr) | ({7'h00, ct_irq_r} << DUT_B_CT);
	end
	// Mask written by host
	always_ff @(posedge clk) begin
		if (rst) irq_mask_reg <= DUT_MASK_RST;
		else if (wr_mask) irq_mask_reg <= wr_data[7:0];
	end
	// Output pin configuration
	always_ff @(posedge clk) begin
		if (rst) opcfg_r <= DUT_OPCFG_RST;
		else if (wr_opcfg != 5'h00 || wr_mask) opcfg_r <= wr_opcfg;
	end
	// Combined active-low interrupt; status reads unmasked
	assign combined_irq_out_n = ~|(irq_status_reg & irq_mask_reg);
	// Discrete active-low pins: 3 ct, 4 rxa, 5 rxb, 6 txa, 7 txb
	always_ff @(posedge clk) begin
		if (rst) begin
			out_pins_three_to_seven <= 5'h1f;
		end else begin
			out_pins_three_to_seven[0] <= ~(opcfg_r[0] & irq_status_reg[DUT_B_CT]);
			out_pins_three_to_seven[1] <= ~(opcfg_r[1] & irq_status_reg[DUT_B_RXA]);
			out_pins_three_to_seven[2] <= ~(opcfg_r[2] & irq_status_reg[DUT_B_RXB]);
			out_pins_three_to_seven[3] <= ~(opcfg_r[3] & irq_status_reg[DUT_B_TXA]);
			out_pins_three_to_seven[4] <= ~(opcfg_r[4] & irq_status_reg[DUT_B_TXB]);
		end
	end
	// The oscillator clock must run for all of the above

	////////////////////////////////////////////////////////////////////////
	// Assertions
	irq_comb_a: assert property (@(posedge clk) disable iff (rst)
		(event_set[DUT_B_RXA] && irq_mask_reg[DUT_B_RXA] && !wr_mask) |=> !combined_irq_out_n)
		else $error("enabled event did not raise irq");
	ct_pin_a: assert property (@(posedge clk) disable iff (rst)
		(opcfg_r[0] && irq_status_reg[DUT_B_CT]) |=> !out_pins_three_to_seven[0])
		else $error("counter irq pin not driven");
	mask_clear_a: assert property (@(posedge clk) disable iff (rst)
		(wr_mask && wr_data[7:0] == 8'h00) |=> combined_irq_out_n)
		else $error("irq stays after mask clear");
	stop_clr_a: assert property (@(posedge clk) disable iff (rst)
		(ct_stop && !ct_zero) |=> !ct_irq_r)
		else $error("stop left counter irq");
	zero_set_a: assert property (@(posedge clk) disable iff (rst)
		ct_zero |=> ##1 irq_status_reg[DUT_B_CT])
		else $error("zero pass not flagged");
	reload_a: assert property (@(posedge clk) disable iff (rst)
		(ct_zero && cmd != DUT_CMD_START && !rx_char_a) |=> cnt_r == ($past(mode_r) == DUT_MODE_TIMER ?
		$past(preset_r) - 16'h0001 : $past(preset_r)))
		else $error("no reload on zero");
	wave_tog_a: assert property (@(posedge clk) disable iff (rst)
		(ct_zero && mode_r == DUT_MODE_TIMER) |=> wave_r != $past(wave_r))
		else $error("square wave did not toggle");
	one_shot_a: assert property (@(posedge clk) disable iff (rst)
		(ct_zero && mode_r == DUT_MODE_COUNTER && cmd == DUT_CMD_NONE) |=> !run_r)
		else $error("counter mode kept running");
	down_cnt_a: assert property (@(posedge clk) disable iff (rst)
		(ct_step && !ct_zero && cmd == DUT_CMD_NONE && !rx_char_a) |=> cnt_r == $past(cnt_r) - 16'h0001)
		else $error("counter not decrementing");
	rx_clr_a: assert property (@(posedge clk) disable iff (rst)
		(rd_rx_holding_a && !event_set[DUT_B_RXA]) |=> !irq_status_reg[DUT_B_RXA])
		else $error("rx irq not cleared");
	access_a: assert property (@(posedge clk) disable iff (rst)
		(!chip_select_n && !read_strobe_n) [*3] |-> access)
		else $error("access missing with select and strobe low");
	cov_timer_c: cover property (@(posedge clk) disable iff (rst) ct_rise);
	cov_irq_c: cover property (@(posedge clk) disable iff (rst) $fell(combined_irq_out_n));
	cov_tmo_c: cover property (@(posedge clk) disable iff (rst)
		(mode_r == DUT_MODE_TIMEOUT && ct_zero));
endmodule // dut_timing_irq
`default_nettype wire

/* File: include/dut_pkg.sv */
// Package of constants for the timing and interrupt section
package dut_pkg;
	// Counter/timer modes
	typedef enum logic [1:0] {
		DUT_MODE_TIMER = 2'b00,
		DUT_MODE_COUNTER = 2'b01,
		DUT_MODE_TIMEOUT = 2'b10
	} dut_mode_e;
	// Host commands on the command port
	typedef enum logic [2:0] {
		DUT_CMD_NONE = 3'b000,
		DUT_CMD_START = 3'b001,
		DUT_CMD_STOP = 3'b010,
		DUT_CMD_WR_PRESET = 3'b011,
		DUT_CMD_RD_VALUE = 3'b100,
		DUT_CMD_SET_TO = 3'b101,
		DUT_CMD_RST_TO = 3'b110
	} dut_cmd_e;
	// Interrupt status bit positions
	localparam int DUT_IRQ_N = 8;
	localparam int DUT_B_TXA = 0;
	localparam int DUT_B_RXA = 1;
	localparam int DUT_B_BRKA = 2;
	localparam int DUT_B_CT = 3;
	localparam int DUT_B_TXB = 4;
	localparam int DUT_B_RXB = 5;
	localparam int DUT_B_BRKB = 6;
	localparam int DUT_B_IPC = 7;
	// Reset values
	localparam logic [7:0] DUT_MASK_RST = 8'h00;
	localparam logic [15:0] DUT_PRESET_RST = 16'h0000;
	localparam logic [4:0] DUT_OPCFG_RST = 5'h00;
	// Baud generator: number of taps and clock selector codes
	localparam int DUT_BAUD_N = 23;
	localparam logic [4:0] DUT_SEL_CT = 5'h17;
	localparam logic [4:0] DUT_SEL_EXT = 5'h18;
	// Oscillator cycles per half period of each 16X tap
	localparam logic [11:0] DUT_BAUD_HALF [DUT_BAUD_N] = '{
		12'h900, 12'h600, 12'h417, 12'h359, 12'h300, 12'h180, 12'h0c0,
		12'h080, 12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010,
		12'h00c, 12'h008, 12'h006, 12'h004, 12'h003, 12'h002, 12'h001,
		12'h0a0, 12'h050};
endpackage

/* File: src/dut_edge.sv */
// Two-flop synchroniser with rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module dut_edge (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic level,
	output logic rise
);
	logic s1_r; // First stage, read only by s2_r
	logic s2_r; // Second stage
	logic s3_r; // Delayed copy for edge
	// Synchronise and delay
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign level = s2_r;
	assign rise = s2_r & ~s3_r;
endmodule // dut_edge
`default_nettype wire

/* File: bench/dut_host.sv */
// Host model: bus strobes, counter commands and mask writes
`timescale 1ns/1ps
`default_nettype none
module dut_host
	import dut_pkg::*;
(
	input wire logic clk,
	output logic chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [2:0] cmd,
	output logic [15:0] wr_data,
	output logic wr_mask,
	output logic [4:0] wr_opcfg
);
	////////////////////////////////////////////////////////////////
	// Idle bus at time zero; released data shows a pattern, not old values
	initial begin
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		cmd = DUT_CMD_NONE;
		wr_data = 16'h5a5a;
		wr_mask = 1'b0;
		wr_opcfg = 5'h00;
	end
	// Raw pin levels, so the bench can pick either order of select and strobe
	task automatic pins(input logic cs, input logic rd, input logic wr);
		@(posedge clk);
		chip_select_n <= cs;
		read_strobe_n <= rd;
		write_strobe_n <= wr;
	endtask
	// Only the six documented commands are ever issued here
	task automatic command(input dut_cmd_e c, input logic [15:0] d);
		@(posedge clk);
		cmd <= c;
		wr_data <= d;
		@(posedge clk);
		cmd <= DUT_CMD_NONE;
		wr_data <= ~d;
	endtask
	// Mask write also carries the discrete pin enables
	task automatic mask(input logic [7:0] m, input logic [4:0] o);
		@(posedge clk);
		wr_mask <= 1'b1;
		wr_data <= {8'h00, m};
		wr_opcfg <= o;
		@(posedge clk);
		wr_mask <= 1'b0;
		wr_data <= {8'hff, ~m};
		wr_opcfg <= 5'h00;
	endtask
endmodule // dut_host
`default_nettype wire

/* File: bench/dual_uart_timing_and_irq_bench.sv */
// Self-checking bench for the timing and interrupt section
`timescale 1ns/1ps
`default_nettype none
module dual_uart_timing_and_irq_bench;
	import dut_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, rd_n, wr_n, wm, acc, acs, ace, irq_n, cto;
	logic [2:0] cmd;
	logic [15:0] wd, cval;
	logic [4:0] opc, pins, sel = 5'h1f;
	logic [7:0] clr = 8'h00, ev = 8'h00, st, msk;
	logic [3:0] en16;
	logic rx_ext_clock = 1'b0, uxc = 1'b0, ctx = 1'b0, cto_d = 1'b0; // Char strobe, ext counter clock
	logic [4:0] selt = 5'h1f; // Transmitter A clock select
	int n_acs = 0, n_ace = 0, n_tg = 0, n_cr = 0, n_en = 0; // One-cycle output tallies
	int errors = 0;
	int n_checks = 0;
	// Free-running oscillator, never stopped
	always #12.5 clk = ~clk;
	dut_host i_host (.clk(clk), .chip_select_n(cs_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .cmd(cmd), .wr_data(wd), .wr_mask(wm), .wr_opcfg(opc));
	dut_timing_irq i_dut (.clk(clk), .rst(rst), .chip_select_n(cs_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .cmd(cmd), .wr_data(wd),
		.wr_mask(wm), .wr_opcfg(opc), .rd_rx_holding_a(clr[1]), .rd_rx_holding_b(clr[5]),
		.wr_tx_holding_a(clr[0]), .wr_tx_holding_b(clr[4]), .rd_input_change(clr[7]),
		.brk_reset_a(clr[2]), .brk_reset_b(clr[6]), .event_set(ev), .use_ext_ct_clk(uxc),
		.counter_ext_clock(ctx), .rx_ext_clock_a(1'b0), .rx_ext_clock_b(1'b0),
		.tx_ext_clock_a(1'b0), .tx_ext_clock_b(clr[3]), .rx_char_a(rx_ext_clock), .sel_rx_a(sel),
		.sel_tx_a(selt), .sel_rx_b(5'h1f), .sel_tx_b(DUT_SEL_EXT), .access(acc),
		.access_start(acs), .access_end(ace), .combined_irq_out_n(irq_n),
		.irq_status_reg(st), .irq_mask_reg(msk), .out_pins_three_to_seven(pins),
		.count_value(cval), .ct_out(cto), .clk16_en(en16));
	////////////////////////////////////////////////////////////////
	// Helpers
	// Tally pulses that stand one cycle; sampled before the edge's updates land
	always @(posedge clk) begin
		if (acs === 1'b1) n_acs++;
		if (ace === 1'b1) n_ace++;
		if (en16[1] === 1'b1) n_en++;
		if (cto !== cto_d) n_tg++;
		if (cto === 1'b1 && cto_d === 1'b0) n_cr++;
		cto_d = cto;
	end
	task automatic close_out;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Settle a few edges, sampling after the updates land
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle pulse on the service clears or on the event inputs
	task automatic pulse(input logic to_clr, input logic [7:0] b);
		@(posedge clk);
		if (to_clr) clr <= b;
		else ev <= b;
		@(posedge clk);
		if (to_clr) clr <= 8'h00;
		else ev <= 8'h00;
		wt(2);
	endtask
	// Cycles until ct_out changes, bounded
	task automatic half(output int n);
		logic s;
		s = cto;
		n = 0;
		while (cto === s) begin
			wt(1);
			n++;
			if (n > 200) begin
				errors++;
				close_out();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic sc_bus;
		i_host.pins(1'b0, 1'b1, 1'b1);
		wt(4);
		chk(acc, 1'b0);
		i_host.pins(1'b0, 1'b0, 1'b1);
		wt(4);
		chk(acc, 1'b1);
		i_host.pins(1'b1, 1'b0, 1'b1);
		wt(4);
		chk(acc, 1'b0);
		i_host.pins(1'b1, 1'b1, 1'b1);
		wt(4);
		chk(n_acs, 16'h0001);
		chk(n_ace, 16'h0001);
	endtask
	task automatic sc_irq;
		pulse(1'b0, 8'h01);
		i_host.mask(8'h02, 5'h02);
		wt(2);
		chk(irq_n, 1'b1);
		pulse(1'b0, 8'h02);
		chk(irq_n, 1'b0);
		chk(pins[1], 1'b0);
		i_host.mask(8'h00, 5'h02);
		wt(2);
		chk(irq_n, 1'b1);
		chk(st, 8'h03);
	endtask
	// Each service action except the counter stop clears only its own status bit
	task automatic sc_clear;
		for (int i = 0; i < 8; i++) begin
			if (i != DUT_B_CT) begin
				pulse(1'b0, 8'hf7);
				pulse(1'b1, 8'h01 << i);
				chk(st, 8'hf7 & ~(8'h01 << i));
			end
		end
	endtask
	task automatic sc_timer;
		int h1, h2;
		i_host.mask(8'h08, 5'h01);
		i_host.command(DUT_CMD_WR_PRESET, 16'h0004);
		i_host.command(DUT_CMD_START, 16'h0000);
		half(h1);
		half(h1);
		half(h2);
		chk(h1, h2);
		chk(h1, 16'h0004);
		chk(st[DUT_B_CT], 1'b1);
		chk(pins[0], 1'b0);
		chk(irq_n, 1'b0);
		i_host.command(DUT_CMD_RD_VALUE, 16'h0000);
		wt(1);
		chk(cval <= 16'h0004, 1'b1);
		i_host.command(DUT_CMD_STOP, 16'h0000);
		wt(3);
		chk(st[DUT_B_CT], 1'b0);
		chk(irq_n, 1'b1);
		chk(pins[0], 1'b1);
	endtask
	// Counter stepped by the external clock only, output used as a 16X source
	task automatic sc_ext;
		int t0, r0, e0;
		@(posedge clk);
		selt <= DUT_SEL_CT;
		uxc <= 1'b1;
		i_host.command(DUT_CMD_START, 16'h0000);
		t0 = n_tg;
		wt(20);
		chk(n_tg - t0, 16'h0000);
		r0 = n_cr;
		e0 = n_en;
		// 40 external rises: first zero at rise 5, then every 4, so 9 toggles
		repeat (40) begin
			@(posedge clk);
			ctx <= 1'b1;
			repeat (2) @(posedge clk);
			ctx <= 1'b0;
			@(posedge clk);
		end
		wt(8);
		chk(n_tg - t0, 16'h0009);
		chk(n_cr - r0, n_en - e0);
		chk(n_en - e0 > 0, 1'b1);
		i_host.command(DUT_CMD_STOP, 16'h0000);
		@(posedge clk);
		uxc <= 1'b0;
	endtask
	// Timeout mode driven by received chars, then single-shot counter mode
	task automatic sc_modes;
		i_host.command(DUT_CMD_SET_TO, 16'h0000);
		i_host.command(DUT_CMD_START, 16'h0000);
		wt(12);
		chk(st[DUT_B_CT], 1'b0);
		// Chars every 3 cycles keep the 5-cycle count from reaching zero
		repeat (6) begin
			@(posedge clk);
			rx_ext_clock <= 1'b1;
			@(posedge clk);
			rx_ext_clock <= 1'b0;
			@(posedge clk);
		end
		#1;
		chk(st[DUT_B_CT], 1'b0);
		wt(8);
		chk(st[DUT_B_CT], 1'b1);
		i_host.command(DUT_CMD_STOP, 16'h0000);
		wt(20);
		chk(st[DUT_B_CT], 1'b0);
		i_host.command(DUT_CMD_RST_TO, 16'h0000);
		i_host.command(DUT_CMD_START, 16'h0000);
		wt(10);
		chk(st[DUT_B_CT], 1'b1);
		i_host.command(DUT_CMD_STOP, 16'h0000);
		wt(20);
		chk(st[DUT_B_CT], 1'b0);
	endtask
	// Faster tap gives more 16X enables in the same window
	task automatic sc_baud;
		int c20, c19;
		c20 = 0;
		c19 = 0;
		@(posedge clk);
		sel <= 5'd20;
		wt(4);
		repeat (64) begin
			wt(1);
			c20 += en16[0];
		end
		@(posedge clk);
		sel <= 5'd19;
		wt(4);
		repeat (64) begin
			wt(1);
			c19 += en16[0];
		end
		chk(c20 > c19 && c19 > 0, 1'b1);
		chk(c20, 64 / (2 * DUT_BAUD_HALF[20]));
		chk(c19, 64 / (2 * DUT_BAUD_HALF[19]));
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		chk(msk, DUT_MASK_RST);
		chk(pins, 5'h1f);
		chk(irq_n, 1'b1);
		sc_bus();
		sc_irq();
		sc_clear();
		sc_timer();
		sc_ext();
		sc_modes();
		sc_baud();
		close_out();
	end
endmodule // dual_uart_timing_and_irq_bench
`default_nettype wire
